// file: design/timer_pwm_map.svh
`ifndef TIMER_PWM_MAP_SVH
`define TIMER_PWM_MAP_SVH

// Register word addresses
`define ADDR_CONTROL_A 3'h0
`define ADDR_CONTROL_B 3'h1
`define ADDR_COUNT 3'h2
`define ADDR_COMPARE_A 3'h3
`define ADDR_COMPARE_B 3'h4
`define ADDR_CAPTURE 3'h5
`define ADDR_FLAGS 3'h6
`define ADDR_PIN_DIR 3'h7

// First control register fields
`define CA_BEH_A_HI 7
`define CA_BEH_A_LO 6
`define CA_BEH_B_HI 5
`define CA_BEH_B_LO 4
`define CA_FORCE_A 3
`define CA_FORCE_B 2
`define CA_MODE_HI 1
`define CA_MODE_LO 0

// Second control register fields
`define CB_MODE_HI 4
`define CB_MODE_LO 3
`define CB_CLKSEL_HI 2
`define CB_CLKSEL_LO 0

// Flag and pin direction bits
`define FLAG_OVERFLOW 0
`define FLAG_COMPARE_A 1
`define FLAG_COMPARE_B 2
`define FLAG_CAPTURE 3
`define PIN_DIR_A 0
`define PIN_DIR_B 1

// Reset values
`define CONTROL_A_RESET 8'h00
`define CONTROL_B_RESET 5'h00
`define VALUE16_RESET 16'h0000
`define FLAGS_RESET 4'h0
`define PIN_DIR_RESET 2'h0

// Counter end points
`define BOTTOM 16'h0000
`define TOP_8BIT 16'h00ff
`define TOP_9BIT 16'h01ff
`define TOP_10BIT 16'h03ff

// Waveform modes
`define MODE_PC_8BIT 4'h1
`define MODE_PC_9BIT 4'h2
`define MODE_PC_10BIT 4'h3
`define MODE_PFC_CAPTURE 4'h8
`define MODE_PFC_COMPARE 4'h9
`define MODE_PC_CAPTURE 4'ha
`define MODE_PC_COMPARE 4'hb
`define MODE_FAST_COMPARE 4'he

// Prescaler selects and terminal masks
`define CLKSEL_DIV1 3'h1
`define CLKSEL_DIV8 3'h2
`define CLKSEL_DIV64 3'h3
`define CLKSEL_DIV256 3'h4
`define CLKSEL_DIV1024 3'h5
`define PRESCALE_LAST_8 10'h007
`define PRESCALE_LAST_64 10'h03f
`define PRESCALE_LAST_256 10'h0ff
`define PRESCALE_LAST_1024 10'h3ff
`define PRESCALE_RESET 10'h000

`endif

// file: design/timer_pwm_pkg.sv
package timer_pwm_pkg;

  // Counting direction of the dual-slope counter
  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } dir_t;

  // Output behaviour select encodings
  typedef enum logic [1:0] {
    BEH_DISCONNECT = 2'b00,
    BEH_TOGGLE = 2'b01,
    BEH_NONINV = 2'b10,
    BEH_INV = 2'b11
  } behaviour_t;

endpackage : timer_pwm_pkg

// file: design/timer_state_if.sv
`timescale 1ns/100ps
`default_nettype none

interface timer_state_if;
  logic tick;
  logic dual_mode;
  logic load;
  logic [15:0] load_value;
  logic [15:0] top_value;
  logic [15:0] count;
  timer_pwm_pkg::dir_t count_dir;

  modport ctrl_end (output tick, output dual_mode, output load, output load_value, output top_value,
                    input count, input count_dir);
  modport counter_end (input tick, input dual_mode, input load, input load_value, input top_value,
                       output count, output count_dir);
  modport unit_end (input tick, input dual_mode, input top_value, input count, input count_dir);
endinterface : timer_state_if

`default_nettype wire

// file: design/dual_slope_counter.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_map.svh"

module dual_slope_counter (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  timer_state_if.counter_end st
);

  // Up to TOP, one tick at TOP, then down to BOTTOM; software load wins over a tick
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st.count <= `VALUE16_RESET; // RULE22
      st.count_dir <= timer_pwm_pkg::DIR_UP;
    end else if (st.load) begin
      st.count <= st.load_value;
    end else if (st.tick && st.dual_mode) begin // RULE18
      case (st.count_dir)
        timer_pwm_pkg::DIR_UP: begin
          // A TOP below the count is missed; the count then wraps through full scale
          if (st.count == st.top_value) begin // RULE6 RULE7
            st.count_dir <= timer_pwm_pkg::DIR_DOWN;
            st.count <= st.count - 16'h0001;
          end else begin
            st.count <= st.count + 16'h0001; // RULE4
          end
        end
        default: begin
          if (st.count == `BOTTOM) begin // RULE4 RULE1
            st.count_dir <= timer_pwm_pkg::DIR_UP;
            st.count <= st.count + 16'h0001;
          end else begin
            st.count <= st.count - 16'h0001;
          end
        end
      endcase
    end
  end

endmodule : dual_slope_counter

`default_nettype wire

// file: design/waveform_output_unit.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_map.svh"

module waveform_output_unit (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  timer_state_if.unit_end st,
  input wire logic [1:0] behaviour_in,
  input wire logic toggle_ok_in,
  input wire logic [15:0] compare_in,
  input wire logic force_in,
  output logic state_out
);

  logic match;
  logic eff_down;

  // Match only on a tick in a dual-slope mode
  assign match = st.tick && st.dual_mode && (st.count == compare_in); // RULE9
  // TOP counts as falling and BOTTOM as rising, so the extreme compare values hold steady
  assign eff_down = (st.count == st.top_value) ? 1'b1 :
                    (st.count == `BOTTOM) ? 1'b0 : (st.count_dir == timer_pwm_pkg::DIR_DOWN); // RULE2 RULE16

  // Output state register
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_out <= 1'b0;
    end else if (match) begin
      case (behaviour_in)
        timer_pwm_pkg::BEH_TOGGLE: begin
          if (toggle_ok_in) begin
            state_out <= ~state_out; // RULE3 RULE17 RULE20
          end
        end
        timer_pwm_pkg::BEH_NONINV: begin
          state_out <= eff_down; // RULE5 RULE14
        end
        timer_pwm_pkg::BEH_INV: begin
          state_out <= ~eff_down; // RULE5 RULE14
        end
        default: begin
          state_out <= state_out;
        end
      endcase
    end else if (force_in && !st.dual_mode) begin
      // Forced match acts only outside PWM, with the non-PWM actions
      case (behaviour_in)
        timer_pwm_pkg::BEH_TOGGLE: state_out <= ~state_out;
        timer_pwm_pkg::BEH_NONINV: state_out <= 1'b0;
        timer_pwm_pkg::BEH_INV: state_out <= 1'b1;
        default: state_out <= state_out;
      endcase
    end
  end

endmodule : waveform_output_unit

`default_nettype wire

// file: design/dual_slope_pwm_timer16.sv
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_map.svh"

// Operation
// RULE1: Output period lasts two times divisor times TOP clocks; divisor 1,8,64,256,1024.
// RULE2: Phase correct: compare at BOTTOM holds low, at TOP holds high; inverted opposite.
// RULE3: Mode 11 with channel A behaviour 1 toggles output A at 50% duty.
// RULE4: Modes 8 and 9 count up from zero to TOP and back down repeatedly.
// RULE5: Non-inverting clears on up-count match, sets on down-count match; inverting reverses.
// RULE6: Mode 8 takes TOP from capture, mode 9 from compare A; TOP reverses direction.
// RULE7: The counter holds TOP for exactly one tick before counting down.
// RULE8: Software keeps the TOP register between 0x0003 and full scale.
// RULE9: A channel flag sets whenever the count equals its compare value.
// RULE10: Frequency correct mode sets overflow flag when compares reload at BOTTOM.
// RULE11: Compare A or capture flag sets at TOP when that register defines TOP.
// RULE12: Software keeps TOP at or above every compare value, else no match.
// RULE13: Compare reload at BOTTOM keeps both slopes equal even when TOP changes.
// RULE14: Behaviour 2 gives non-inverted waveform, behaviour 3 inverted.
// RULE15: Waveform reaches the pin only when its direction bit selects output.
// RULE16: Frequency correct: compare at BOTTOM keeps low, at TOP keeps high; inverted opposite.
// RULE17: Mode 9 with channel A behaviour 1 toggles output A at 50% duty.
// RULE18: Fully synchronous; counting and flags advance only on the tick enable.
// RULE19: Control A: behaviour A 7:6, B 5:4, force strobes 3 and 2, mode 1:0.
// RULE20: Behaviour 1 toggles A only in modes 9, 11 or 14; otherwise disconnected.
// RULE21: Low mode bits join the two high bits of control B into the mode.
// RULE22: Reset leaves counter at BOTTOM counting up, outputs disconnected, flags clear.
module dual_slope_pwm_timer16 (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [15:0] reg_rdata_out,
  output logic waveform_out_a_out,
  output logic waveform_oe_a_out,
  output logic waveform_out_b_out,
  output logic waveform_oe_b_out
);

  localparam int CHANNELS = 2;
  // Reset images of both control registers, held as constants so their fields can be sliced
  localparam logic [7:0] CONTROL_A_INIT = `CONTROL_A_RESET;
  localparam logic [4:0] CONTROL_B_INIT = `CONTROL_B_RESET;

  // Software-visible registers
  logic [1:0] behaviour_a_q;
  logic [1:0] behaviour_b_q;
  logic [1:0] mode_low_q;
  logic [1:0] mode_high_q;
  logic [2:0] clock_select_q;
  logic [15:0] capture_top_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [1:0] pin_direction_q;
  logic [15:0] rdata_q;

  // Per-channel compare storage
  logic [15:0] compare_buffer_q [CHANNELS];
  logic [15:0] compare_active_q [CHANNELS];
  logic [1:0] behaviour [CHANNELS];
  logic toggle_ok [CHANNELS];
  logic force_strobe [CHANNELS];
  logic wave_state [CHANNELS];
  logic connected [CHANNELS];
  logic [2:0] compare_addr [CHANNELS];

  // Mode decode
  logic [3:0] waveform_mode_select;
  logic phase_freq_mode;
  logic phase_mode;
  logic dual_mode;
  logic capture_is_top;
  logic compare_a_is_top;
  logic [15:0] top_value;

  // Prescaler
  logic [9:0] prescale_q;
  logic timer_tick_enable;

  // Event terms
  logic at_top;
  logic at_bottom;
  logic compare_update;
  logic [3:0] flag_set;
  logic [3:0] flag_clear;

  // Register strobes
  logic write_control_a;
  logic write_control_b;
  logic write_count;
  logic write_capture;
  logic write_flags;
  logic write_pin_dir;

  timer_state_if st ();

  // Address decode for writes
  always_comb begin
    write_control_a = 1'b0;
    write_control_b = 1'b0;
    write_count = 1'b0;
    write_capture = 1'b0;
    write_flags = 1'b0;
    write_pin_dir = 1'b0;
    if (!reg_write_in) begin
      write_control_a = 1'b0;
    end else if (reg_addr_in == `ADDR_CONTROL_A) begin
      write_control_a = 1'b1;
    end else if (reg_addr_in == `ADDR_CONTROL_B) begin
      write_control_b = 1'b1;
    end else if (reg_addr_in == `ADDR_COUNT) begin
      write_count = 1'b1;
    end else if (reg_addr_in == `ADDR_CAPTURE) begin
      write_capture = 1'b1;
    end else if (reg_addr_in == `ADDR_FLAGS) begin
      write_flags = 1'b1;
    end else if (reg_addr_in == `ADDR_PIN_DIR) begin
      write_pin_dir = 1'b1;
    end
  end

  // First control register; the force bits are strobes and are not stored
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      behaviour_a_q <= CONTROL_A_INIT[`CA_BEH_A_HI:`CA_BEH_A_LO]; // RULE19 RULE22
      behaviour_b_q <= CONTROL_A_INIT[`CA_BEH_B_HI:`CA_BEH_B_LO];
      mode_low_q <= CONTROL_A_INIT[`CA_MODE_HI:`CA_MODE_LO];
    end else if (write_control_a) begin
      behaviour_a_q <= reg_wdata_in[`CA_BEH_A_HI:`CA_BEH_A_LO]; // RULE19
      behaviour_b_q <= reg_wdata_in[`CA_BEH_B_HI:`CA_BEH_B_LO];
      mode_low_q <= reg_wdata_in[`CA_MODE_HI:`CA_MODE_LO];
    end
  end

  // Force strobes last exactly the write cycle
  assign force_strobe[0] = write_control_a && reg_wdata_in[`CA_FORCE_A]; // RULE19
  assign force_strobe[1] = write_control_a && reg_wdata_in[`CA_FORCE_B];

  // Second control register: high mode bits and prescaler select
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_high_q <= CONTROL_B_INIT[`CB_MODE_HI:`CB_MODE_LO];
      clock_select_q <= CONTROL_B_INIT[`CB_CLKSEL_HI:`CB_CLKSEL_LO];
    end else if (write_control_b) begin
      mode_high_q <= reg_wdata_in[`CB_MODE_HI:`CB_MODE_LO];
      clock_select_q <= reg_wdata_in[`CB_CLKSEL_HI:`CB_CLKSEL_LO];
    end
  end

  // Capture register is not double buffered, so a TOP write takes effect at once
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      capture_top_q <= `VALUE16_RESET;
    end else if (write_capture) begin
      capture_top_q <= reg_wdata_in; // RULE8
    end
  end

  // Pin direction bits
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_direction_q <= `PIN_DIR_RESET;
    end else if (write_pin_dir) begin
      pin_direction_q <= reg_wdata_in[1:0];
    end
  end

  // Four-bit mode from both control registers
  assign waveform_mode_select = {mode_high_q, mode_low_q}; // RULE21

  always_comb begin
    phase_freq_mode = 1'b0;
    phase_mode = 1'b0;
    capture_is_top = 1'b0;
    compare_a_is_top = 1'b0;
    top_value = `TOP_8BIT;
    case (waveform_mode_select)
      `MODE_PC_8BIT: begin
        phase_mode = 1'b1;
        top_value = `TOP_8BIT;
      end
      `MODE_PC_9BIT: begin
        phase_mode = 1'b1;
        top_value = `TOP_9BIT;
      end
      `MODE_PC_10BIT: begin
        phase_mode = 1'b1;
        top_value = `TOP_10BIT;
      end
      `MODE_PFC_CAPTURE: begin
        phase_freq_mode = 1'b1; // RULE4
        capture_is_top = 1'b1;
        top_value = capture_top_q; // RULE6
      end
      `MODE_PFC_COMPARE: begin
        phase_freq_mode = 1'b1; // RULE4
        compare_a_is_top = 1'b1;
        top_value = compare_active_q[0]; // RULE6
      end
      `MODE_PC_CAPTURE: begin
        phase_mode = 1'b1;
        capture_is_top = 1'b1;
        top_value = capture_top_q;
      end
      `MODE_PC_COMPARE: begin
        phase_mode = 1'b1;
        compare_a_is_top = 1'b1;
        top_value = compare_active_q[0];
      end
      default: begin
        top_value = `TOP_8BIT;
      end
    endcase
  end

  assign dual_mode = phase_freq_mode || phase_mode;

  // Free-running prescaler; a tick when the low bits of the divisor are all ones
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prescale_q <= `PRESCALE_RESET;
    end else begin
      prescale_q <= prescale_q + 10'h001;
    end
  end

  // Tick enable; selects other than the five divisors stop the timer
  always_comb begin
    case (clock_select_q)
      `CLKSEL_DIV1: timer_tick_enable = 1'b1; // RULE1
      `CLKSEL_DIV8: timer_tick_enable = (prescale_q & `PRESCALE_LAST_8) == `PRESCALE_LAST_8;
      `CLKSEL_DIV64: timer_tick_enable = (prescale_q & `PRESCALE_LAST_64) == `PRESCALE_LAST_64;
      `CLKSEL_DIV256: timer_tick_enable = (prescale_q & `PRESCALE_LAST_256) == `PRESCALE_LAST_256;
      `CLKSEL_DIV1024: timer_tick_enable = prescale_q == `PRESCALE_LAST_1024; // RULE1
      default: timer_tick_enable = 1'b0;
    endcase
  end

  // Shared counter state
  assign st.tick = timer_tick_enable; // RULE18
  assign st.dual_mode = dual_mode;
  assign st.load = write_count;
  assign st.load_value = reg_wdata_in;
  assign st.top_value = top_value;

  dual_slope_counter u_counter (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .st(st.counter_end)
  );

  // End point events, only on a tick in a dual-slope mode
  assign at_top = timer_tick_enable && dual_mode && (st.count == top_value);
  assign at_bottom = timer_tick_enable && dual_mode && (st.count == `BOTTOM);
  // Frequency correct reloads at BOTTOM, phase correct at TOP
  assign compare_update = phase_freq_mode ? at_bottom : at_top; // RULE13

  assign toggle_ok[0] = (waveform_mode_select == `MODE_PFC_COMPARE) ||
                        (waveform_mode_select == `MODE_PC_COMPARE) ||
                        (waveform_mode_select == `MODE_FAST_COMPARE); // RULE20
  assign toggle_ok[1] = 1'b0; // RULE20
  assign behaviour[0] = behaviour_a_q;
  assign behaviour[1] = behaviour_b_q;
  assign compare_addr[0] = `ADDR_COMPARE_A;
  assign compare_addr[1] = `ADDR_COMPARE_B;

  // Per-channel double buffer, output unit and pin connection
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
      // Software always writes the buffer; the active copy follows at the update point
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          compare_buffer_q[ch] <= `VALUE16_RESET;
        end else if (reg_write_in && (reg_addr_in == compare_addr[ch])) begin
          compare_buffer_q[ch] <= reg_wdata_in;
        end
      end

      // Outside the dual-slope modes the active copy tracks the buffer directly
      always_ff @(posedge core_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          compare_active_q[ch] <= `VALUE16_RESET;
        end else if (!dual_mode || compare_update) begin
          compare_active_q[ch] <= compare_buffer_q[ch]; // RULE13
        end
      end

      waveform_output_unit u_unit (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .st(st.unit_end),
        .behaviour_in(behaviour[ch]),
        .toggle_ok_in(toggle_ok[ch]),
        .compare_in(compare_active_q[ch]),
        .force_in(force_strobe[ch]),
        .state_out(wave_state[ch])
      );

      // A toggle select without the toggle option leaves the pin to the port
      assign connected[ch] = (behaviour[ch] != timer_pwm_pkg::BEH_DISCONNECT) &&
                             ((behaviour[ch] != timer_pwm_pkg::BEH_TOGGLE) || toggle_ok[ch]); // RULE20
    end
  endgenerate

  // Pin drive: waveform visible only with direction set to output
  assign waveform_out_a_out = wave_state[0];
  assign waveform_oe_a_out = connected[0] && pin_direction_q[`PIN_DIR_A]; // RULE15
  assign waveform_out_b_out = wave_state[1];
  assign waveform_oe_b_out = connected[1] && pin_direction_q[`PIN_DIR_B]; // RULE15

  // Flag events
  assign flag_set[`FLAG_OVERFLOW] = at_bottom; // RULE10
  assign flag_set[`FLAG_COMPARE_A] = timer_tick_enable && dual_mode && (st.count == compare_active_q[0]); // RULE9 RULE11
  assign flag_set[`FLAG_COMPARE_B] = timer_tick_enable && dual_mode && (st.count == compare_active_q[1]); // RULE9
  assign flag_set[`FLAG_CAPTURE] = at_top && capture_is_top; // RULE11
  assign flag_clear = write_flags ? reg_wdata_in[3:0] : 4'h0;

  // A set in the same cycle as a clear wins
  assign flags_d = (flags_q & ~flag_clear) | flag_set;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_q <= `FLAGS_RESET; // RULE22
    end else begin
      flags_q <= flags_d;
    end
  end

  // Read data registered for the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= `VALUE16_RESET;
    end else if (!reg_read_in) begin
      rdata_q <= `VALUE16_RESET;
    end else if (reg_addr_in == `ADDR_CONTROL_A) begin
      rdata_q <= {8'h00, behaviour_a_q, behaviour_b_q, 2'b00, mode_low_q}; // RULE19
    end else if (reg_addr_in == `ADDR_CONTROL_B) begin
      rdata_q <= {11'h000, mode_high_q, clock_select_q};
    end else if (reg_addr_in == `ADDR_COUNT) begin
      rdata_q <= st.count;
    end else if (reg_addr_in == `ADDR_COMPARE_A) begin
      rdata_q <= compare_buffer_q[0];
    end else if (reg_addr_in == `ADDR_COMPARE_B) begin
      rdata_q <= compare_buffer_q[1];
    end else if (reg_addr_in == `ADDR_CAPTURE) begin
      rdata_q <= capture_top_q;
    end else if (reg_addr_in == `ADDR_FLAGS) begin
      rdata_q <= {12'h000, flags_q};
    end else if (reg_addr_in == `ADDR_PIN_DIR) begin
      rdata_q <= {14'h0000, pin_direction_q};
    end else begin
      rdata_q <= `VALUE16_RESET;
    end
  end

  assign reg_rdata_out = rdata_q;

endmodule : dual_slope_pwm_timer16

`default_nettype wire

// file: tb/pwm_timer_checker_sva.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_map.svh"

module pwm_timer_checker (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [2:0] reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [15:0] reg_rdata_out,
  input wire logic waveform_out_a_out,
  input wire logic waveform_oe_a_out,
  input wire logic waveform_out_b_out,
  input wire logic waveform_oe_b_out
);
  logic [7:0] ctla_q;
  logic [4:0] ctlb_q;
  logic [1:0] dir_q;
  logic cfg_q;
  logic [3:0] mode;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // Shadow of software settings, so pin rules can be judged from the bus
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctla_q <= 8'h00;
      ctlb_q <= 5'h00;
      dir_q <= 2'h0;
      cfg_q <= 1'b0;
    end else if (reg_write_in) begin
      if (reg_addr_in == `ADDR_CONTROL_A) ctla_q <= reg_wdata_in[7:0];
      if (reg_addr_in == `ADDR_CONTROL_B) ctlb_q <= reg_wdata_in[4:0];
      if (reg_addr_in == `ADDR_PIN_DIR) dir_q <= reg_wdata_in[1:0];
      if (reg_addr_in == `ADDR_CONTROL_A && reg_wdata_in[7:4] != 4'h0) cfg_q <= 1'b1;
    end
  end

  assign mode = {ctlb_q[4:3], ctla_q[1:0]};

  a_rdata_idle: assert property (!$past(reg_read_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data not zero outside read answer");
  a_ctla_readback: assert property (
    $past(reg_read_in) && $past(reg_addr_in) == `ADDR_CONTROL_A
    |-> reg_rdata_out == {8'h00, ctla_q[7:4], 2'b00, ctla_q[1:0]})
    else $error("control A readback wrong");
  a_dir_gates_a: assert property (waveform_oe_a_out |-> dir_q[0])
    else $error("pin A driven while direction is input");
  a_dir_gates_b: assert property (waveform_oe_b_out |-> dir_q[1])
    else $error("pin B driven while direction is input");
  a_b_no_toggle: assert property (waveform_oe_b_out |-> ctla_q[5])
    else $error("pin B driven with behaviour 0 or 1");
  a_oe_a_beh: assert property (
    waveform_oe_a_out |-> ctla_q[7] || (ctla_q[6] && mode inside {4'h9, 4'hb, 4'he}))
    else $error("pin A driven without a connecting behaviour");
  a_oe_b_on: assert property (ctla_q[5] && dir_q[1] |-> waveform_oe_b_out)
    else $error("pin B not driven in PWM behaviour");
  a_quiet_reset: assert property (
    !cfg_q |-> !waveform_out_a_out && !waveform_out_b_out && !waveform_oe_a_out && !waveform_oe_b_out)
    else $error("output active before configuration");
  a_stopped_hold: assert property (
    ctlb_q[2:0] == 3'h0 && $past(ctlb_q[2:0]) == 3'h0 && !$past(reg_write_in)
    |-> $stable(waveform_out_a_out) && $stable(waveform_out_b_out))
    else $error("output moved while timer stopped");
endmodule : pwm_timer_checker

bind dual_slope_pwm_timer16 pwm_timer_checker i_pwm_timer_checker (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out), .waveform_out_a_out(waveform_out_a_out),
  .waveform_oe_a_out(waveform_oe_a_out), .waveform_out_b_out(waveform_out_b_out),
  .waveform_oe_b_out(waveform_oe_b_out));

`default_nettype wire

// file: tb/dual_slope_pwm_timer16_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "timer_pwm_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end

module dual_slope_pwm_timer16_bench;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [15:0] reg_wdata_in = 16'h0000;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [15:0] reg_rdata_out;
  logic out_a, oe_a, out_b, oe_b;
  int mismatches = 0;
  int checks_done = 0;
  int divs[5] = '{1, 8, 64, 256, 1024};

  dual_slope_pwm_timer16 i_dual_slope_pwm_timer16 (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
    .reg_rdata_out(reg_rdata_out), .waveform_out_a_out(out_a), .waveform_oe_a_out(oe_a),
    .waveform_out_b_out(out_b), .waveform_oe_b_out(oe_b));

  // 125 MHz core clock
  initial begin
    forever #4 core_clk_in = ~core_clk_in;
  end

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask : wr

  // Read data is only valid in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1;
    `CHK(reg_rdata_out, e)
  endtask : rd_chk

  // High cycles over two periods; a match at c keeps the pin high for 2c ticks
  function automatic int exp_hi(bit tog, bit inv, int c, int top, int n);
    if (tog) return 2 * n * top;
    return 4 * n * (inv ? top - c : c);
  endfunction : exp_hi

  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial begin
    #780000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    int n, top, c, ca;
    logic [31:0] ha, hb;
    logic [3:0] mode;
    logic [1:0] beh, beh_a;
    logic [7:0] ctla;
    logic [2:0] sel;
    bit tog;
    void'($urandom(32'h2ed0cf0e));
    repeat (16) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    for (int a = 0; a < 8; a++) rd_chk(3'(a), 16'h0000);
    `CHK({out_a, oe_a, out_b, oe_b}, 4'h0)
    // Dual-slope modes 1, 8, 9, 10 and 11, both polarities, every divisor, compare corners
    for (int i = 0; i < 9; i++) begin
      mode = (i < 8) ? (4'h8 | 4'(i % 4)) : `MODE_PC_8BIT;
      beh = (i < 4) ? 2'h2 : 2'h3;
      tog = mode[3] & mode[0];
      beh_a = tog ? 2'h1 : beh;
      sel = (i < 5) ? 3'(i + 1) : (i < 8) ? 3'(i - 4) : `CLKSEL_DIV1;
      n = divs[sel - 1];
      top = mode[3] ? 3 + $urandom_range(n > 8 ? 1 : 12) : 32'(`TOP_8BIT);
      c = (i % 3 == 0) ? 0 : (i % 3 == 1) ? top : $urandom_range(top - 1, 1);
      ca = $urandom_range(top);
      wr(`ADDR_COUNT, 16'h0000);
      wr(`ADDR_COMPARE_B, 16'(c));
      wr(`ADDR_COMPARE_A, 16'(tog ? top : ca));
      wr(`ADDR_CAPTURE, 16'(top));
      wr(`ADDR_PIN_DIR, 16'h0003);
      ctla = {beh_a, beh, 2'b11, mode[1:0]};
      wr(`ADDR_CONTROL_A, {8'h00, ctla});
      rd_chk(`ADDR_CONTROL_A, {8'h00, ctla & 8'hf3});
      wr(`ADDR_CONTROL_B, {11'h000, mode[3:2], sel});
      repeat (6 * n * top) @(posedge core_clk_in);
      ha = 32'h0;
      hb = 32'h0;
      repeat (4 * n * top) begin
        @(posedge core_clk_in);
        #1;
        ha = ha + 32'(out_a);
        hb = hb + 32'(out_b);
      end
      `CHK(ha, 32'(exp_hi(tog, beh_a == 2'h3, ca, top, n)))
      `CHK(hb, 32'(exp_hi(1'b0, beh == 2'h3, c, top, n)))
      `CHK({oe_a, oe_b}, 2'b11)
      rd_chk(`ADDR_FLAGS, {12'h000, mode[3] & ~mode[0], 3'b111});
      // Stop before clearing, since a set wins over a clear
      wr(`ADDR_CONTROL_B, 16'h0000);
      wr(`ADDR_FLAGS, 16'h000f);
      rd_chk(`ADDR_FLAGS, 16'h0000);
      wr(`ADDR_PIN_DIR, 16'h0000);
      #1;
      `CHK({oe_a, oe_b}, 2'b00)
      // Mode 0 lets the active compares follow the buffers, so no stale TOP survives
      wr(`ADDR_CONTROL_A, 16'h0000);
    end
    // Forced matches outside PWM act with the behaviour already held
    wr(`ADDR_CONTROL_A, 16'h00b0);
    wr(`ADDR_CONTROL_A, 16'h00bc);
    #1;
    `CHK({out_a, out_b}, 2'b01)
    wr(`ADDR_CONTROL_A, 16'h00e0);
    wr(`ADDR_CONTROL_A, 16'h00ec);
    #1;
    `CHK({out_a, out_b}, 2'b10)
    report_and_stop();
  end
endmodule : dual_slope_pwm_timer16_bench

`default_nettype wire
